// *** cis_pkg.sv ***
// Purpose: shared constants for the interrupt sequencer
// Assumes: 16-bit word program counter, 200 MHz cpu clock
// Notes: register offsets are byte addresses on the AHB-Lite slave
package cis_pkg;
    // ----------------------------------------
    // sources and vectors
    // ----------------------------------------
    localparam int NSRC = 8;
    localparam logic [15:0] VEC_STRIDE = 16'h0002;
    localparam logic [15:0] BOOT_BASE_RST = 16'hF000;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] OFS_FLAGS = 8'h00;
    localparam logic [7:0] OFS_ENABLE = 8'h04;
    localparam logic [7:0] OFS_PENDING = 8'h08;
    localparam logic [7:0] OFS_CTRL = 8'h0C;
    localparam logic [7:0] OFS_SP = 8'h10;
    localparam logic [7:0] OFS_BOOT = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam int GATE_BIT = 7;
    localparam int CTRL_RELOC_BIT = 1;
    localparam logic [15:0] SP_RESET = 16'h10FF;
    localparam logic [15:0] BOOT_START_RESET = 16'hF000;
    // ----------------------------------------
    // timing counts in cycles
    // ----------------------------------------
    localparam logic [2:0] ENTRY_CYC = 3'h4;
    localparam logic [2:0] WAKE_EXTRA_CYC = 3'h4;
    localparam logic [2:0] JUMP_CYC = 3'h3;
    localparam logic [2:0] RETURN_CYC = 3'h4;
    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_WAKE = 3'b001,
        ST_ENTRY = 3'b010,
        ST_JUMP = 3'b011,
        ST_RET = 3'b100
    } cis_state_t;
endpackage : cis_pkg

// *** cis_sequencer.sv ***
// Purpose: interrupt gating, priority, vectoring and entry/return sequencing
// Assumes: pipeline gives one-cycle instruction pulses; sources are async pins
// Notes: single clock, AHB-Lite register slave, zero wait states
//
// The address map and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1 - reset and each source own a distinct vector, default at lowest addresses
// R2 - serve a source only if its enable and the global gate are both set
// R3 - lowest vector address wins; reset first, then external request zero
// R4 - relocation bit moves the interrupt table to the boot section start
// R5 - boot reset fuse fetches the reset vector from the boot section start
// R6 - boot lock bits suppress interrupts depending on program counter region
// R7 - accepting an interrupt clears the global gate; software may set it again
// R8 - flag sources have their pending flag cleared when vectored
// R9 - writing one to a pending flag clears it, zero leaves it
// R10 - flag sets and holds even while its own enable is clear
// R11 - flags stay latched while gate is clear, then served by priority
// R12 - level sources request only while their condition is present
// R13 - after return, one main instruction runs before the next service
// R14 - flags register is neither saved on entry nor restored on return
// R15 - global disable acts at once, even against a same-cycle request
// R16 - after global enable, the next instruction runs before any service
// R17 - entry takes four cycles and pushes the program counter
// R18 - the vector jump takes three cycles to reach the handler
// R19 - a multi-cycle instruction completes before entry begins
// R20 - wake from sleep adds four cycles to entry
// R21 - return takes four cycles, pops pc, adds two to sp, sets gate
// R22 - entry subtracts two from the stack pointer
// R23 - vectors sit at fixed stride from the chosen base, index gives priority
module cis_sequencer (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [cis_pkg::NSRC-1:0] src_event,
    input wire logic [cis_pkg::NSRC-1:0] src_is_level,
    input wire logic instr_done,
    input wire logic instr_multi_busy,
    input wire logic global_disable_op,
    input wire logic global_enable_op,
    input wire logic return_from_handler,
    input wire logic sleeping,
    input wire logic boot_reset_vector_fuse,
    input wire logic boot_lock_app_bits,
    input wire logic boot_lock_boot_bits,
    input wire logic [15:0] cur_pc,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq_stall,
    output logic pc_load,
    output logic [15:0] pc_target,
    output logic push_pulse,
    output logic pop_pulse,
    output logic [15:0] ret_addr,
    output logic [15:0] sp_out
);
    import cis_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [NSRC-1:0] s1;
        logic [NSRC-1:0] s2;
        logic [NSRC-1:0] s3;
        logic [NSRC-1:0] lvl;
        logic [NSRC-1:0] pend;
        logic [NSRC-1:0] en;
        logic [7:0] flags;
        logic [7:0] ctrl;
        logic [15:0] sp;
        logic [15:0] boot_start;
        logic [15:0] ret;
        logic [15:0] tgt;
        logic [NSRC-1:0] serving;
        cis_state_t st;
        logic [2:0] cnt;
        logic hold_one;
        logic rst_vec_done;
        logic aph_wr;
        logic aph_rd;
        logic [7:0] aph_ofs;
        logic [31:0] rdata;
        logic pc_load;
        logic push;
        logic pop;
        logic stall;
    } cis_st_t;

    cis_st_t q, d;

    function automatic logic [NSRC-1:0] lowest_one(input logic [NSRC-1:0] v);
        logic [NSRC-1:0] r;
        r = '0;
        for (int i = NSRC - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = '0;
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction : lowest_one

    function automatic logic [15:0] vec_addr(input logic [15:0] base, input logic [NSRC-1:0] oh);
        logic [15:0] a;
        a = base;
        for (int i = 0; i < NSRC; i++)
        begin
            if (oh[i])
            begin
                a = base + VEC_STRIDE * 16'(i + 1); // [R23] [R1]
            end
        end
        return a;
    endfunction : vec_addr

    // ----------------------------------------
    // combinational next state
    // ----------------------------------------
    logic [NSRC-1:0] rise, req, pick;
    logic [15:0] tbase;
    logic in_boot, locked, may_take;

    always_comb
    begin
        d = q;
        d.pc_load = 1'b0;
        d.push = 1'b0;
        d.pop = 1'b0;
        // three-stage sync; s2/s3 agreement qualifies the level
        d.s1 = src_event;
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int i = 0; i < NSRC; i++)
        begin
            if (q.s2[i] == q.s3[i])
            begin
                d.lvl[i] = q.s2[i];
            end
        end
        rise = d.lvl & ~q.lvl & ~src_is_level;
        // level sources follow the condition directly, never latched
        req = ((q.pend & ~src_is_level) | (q.lvl & src_is_level)) & q.en; // [R12] [R2]
        pick = lowest_one(req); // [R3]
        tbase = q.ctrl[CTRL_RELOC_BIT] ? q.boot_start : 16'h0000; // [R4]
        in_boot = cur_pc >= q.boot_start;
        // lock bits mask interrupts while executing in the protected region
        locked = (boot_lock_app_bits && !in_boot) || (boot_lock_boot_bits && in_boot); // [R6]
        may_take = q.flags[GATE_BIT] && !global_disable_op && !q.hold_one && !locked
                   && !instr_multi_busy && instr_done && (req != '0); // [R15] [R19] [R11]
        // ahb data phase
        if (q.aph_wr)
        begin
            if (q.aph_ofs == OFS_FLAGS)
            begin
                d.flags = hwdata[7:0];
            end
            else if (q.aph_ofs == OFS_ENABLE)
            begin
                d.en = hwdata[NSRC-1:0];
            end
            else if (q.aph_ofs == OFS_PENDING)
            begin
                d.pend = q.pend & ~hwdata[NSRC-1:0]; // [R9]
            end
            else if (q.aph_ofs == OFS_CTRL)
            begin
                d.ctrl = hwdata[7:0];
            end
            else if (q.aph_ofs == OFS_SP)
            begin
                d.sp = hwdata[15:0];
            end
            else if (q.aph_ofs == OFS_BOOT)
            begin
                d.boot_start = hwdata[15:0];
            end
        end
        d.aph_wr = hsel && hready && htrans[1] && hwrite;
        d.aph_rd = hsel && hready && htrans[1] && !hwrite;
        d.aph_ofs = haddr[7:0];
        d.rdata = '0;
        if (d.aph_rd)
        begin
            if (haddr[7:0] == OFS_FLAGS)
            begin
                d.rdata = {24'h000000, q.flags};
            end
            else if (haddr[7:0] == OFS_ENABLE)
            begin
                d.rdata = {24'h000000, q.en};
            end
            else if (haddr[7:0] == OFS_PENDING)
            begin
                d.rdata = {24'h000000, q.pend};
            end
            else if (haddr[7:0] == OFS_CTRL)
            begin
                d.rdata = {24'h000000, q.ctrl};
            end
            else if (haddr[7:0] == OFS_SP)
            begin
                d.rdata = {16'h0000, q.sp};
            end
            else if (haddr[7:0] == OFS_BOOT)
            begin
                d.rdata = {16'h0000, q.boot_start};
            end
            else if (haddr[7:0] == OFS_STATUS)
            begin
                d.rdata = {21'h000000, q.st, q.serving};
            end
        end
        // flag latch ignores enables and gate; set beats software clear
        d.pend = d.pend | rise; // [R10] [R11]
        if (global_disable_op)
        begin
            d.flags[GATE_BIT] = 1'b0; // [R15]
        end
        if (global_enable_op)
        begin
            d.flags[GATE_BIT] = 1'b1;
            d.hold_one = 1'b1; // [R16]
        end
        else if (instr_done && q.hold_one)
        begin
            d.hold_one = 1'b0; // [R13] [R16]
        end
        case (q.st)
            ST_RUN:
            begin
                if (!q.rst_vec_done)
                begin
                    d.rst_vec_done = 1'b1;
                    d.pc_load = 1'b1;
                    d.tgt = boot_reset_vector_fuse ? BOOT_BASE_RST : 16'h0000; // [R5] [R3]
                end
                else if (return_from_handler)
                begin
                    d.st = ST_RET;
                    d.cnt = RETURN_CYC - 3'h1;
                    d.stall = 1'b1;
                end
                else if (may_take)
                begin
                    d.flags[GATE_BIT] = 1'b0; // [R7] [R14]
                    d.serving = pick;
                    d.pend = d.pend & ~(pick & ~src_is_level); // [R8]
                    d.ret = cur_pc;
                    d.tgt = vec_addr(tbase, pick); // [R23]
                    d.stall = 1'b1;
                    d.st = sleeping ? ST_WAKE : ST_ENTRY;
                    d.cnt = sleeping ? WAKE_EXTRA_CYC - 3'h1 : ENTRY_CYC - 3'h1;
                end
            end
            ST_WAKE:
            begin
                d.cnt = q.cnt - 3'h1;
                if (q.cnt == 3'h0)
                begin
                    d.st = ST_ENTRY; // [R20]
                    d.cnt = ENTRY_CYC - 3'h1;
                end
            end
            ST_ENTRY:
            begin
                d.cnt = q.cnt - 3'h1;
                if (q.cnt == 3'h0)
                begin
                    d.push = 1'b1; // [R17]
                    d.sp = q.sp - 16'h0002; // [R22]
                    d.pc_load = 1'b1;
                    d.st = ST_JUMP;
                    d.cnt = JUMP_CYC - 3'h1;
                end
            end
            ST_JUMP:
            begin
                d.cnt = q.cnt - 3'h1;
                if (q.cnt == 3'h0)
                begin
                    d.st = ST_RUN; // [R18]
                    d.stall = 1'b0;
                end
            end
            ST_RET:
            begin
                d.cnt = q.cnt - 3'h1;
                if (q.cnt == 3'h0)
                begin
                    d.pop = 1'b1;
                    d.sp = q.sp + 16'h0002; // [R21]
                    d.flags[GATE_BIT] = 1'b1; // [R21] [R14]
                    d.hold_one = 1'b1; // [R13]
                    d.serving = '0;
                    d.st = ST_RUN;
                    d.stall = 1'b0;
                end
            end
            default:
            begin
                d.st = ST_RUN;
            end
        endcase
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
            q.sp <= SP_RESET;
            q.boot_start <= BOOT_START_RESET;
            q.st <= ST_RUN;
        end
        else
        begin
            q <= d;
        end
    end

    assign hrdata = q.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign irq_stall = q.stall;
    assign pc_load = q.pc_load;
    assign pc_target = q.tgt;
    assign push_pulse = q.push;
    assign pop_pulse = q.pop;
    assign ret_addr = q.ret;
    assign sp_out = q.sp;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_GATE_CLEARED_ON_ENTRY: assert property (@(posedge clock) disable iff (!rst_n) // [R7]
        (q.st == ST_RUN && d.st == ST_ENTRY) |=> !q.flags[GATE_BIT])
        else $error("gate not cleared on entry");
    AST_ENTRY_FOUR: assert property (@(posedge clock) disable iff (!rst_n) // [R17]
        ($rose(q.st == ST_ENTRY)) |-> ##3 q.push == 1'b0 ##1 q.push)
        else $error("entry not four cycles");
    AST_SP_DOWN_TWO: assert property (@(posedge clock) disable iff (!rst_n) // [R22]
        (q.st == ST_ENTRY && q.cnt == 3'h0) |=> q.sp == $past(q.sp) - 16'h0002)
        else $error("sp not decremented by two");
    AST_RET_FOUR: assert property (@(posedge clock) disable iff (!rst_n) // [R21]
        ($rose(q.st == ST_RET)) |-> ##4 (q.pop && q.flags[GATE_BIT]))
        else $error("return timing wrong");
    AST_CLI_BLOCKS: assert property (@(posedge clock) disable iff (!rst_n) // [R15]
        global_disable_op |=> q.st != ST_ENTRY && q.st != ST_WAKE)
        else $error("interrupt after disable");
    AST_NO_TAKE_WITHOUT_GATE: assert property (@(posedge clock) disable iff (!rst_n) // [R2]
        (q.st == ST_RUN && !q.flags[GATE_BIT]) |=> !(q.st inside {ST_ENTRY, ST_WAKE}))
        else $error("taken with gate clear");
    AST_JUMP_THREE: assert property (@(posedge clock) disable iff (!rst_n) // [R18]
        $rose(q.st == ST_JUMP) |-> (q.st == ST_JUMP) [*3] ##1 q.st == ST_RUN)
        else $error("jump not three cycles");
    AST_WAKE_EXTRA: assert property (@(posedge clock) disable iff (!rst_n) // [R20]
        $rose(q.st == ST_WAKE) |-> (q.st == ST_WAKE) [*4] ##1 q.st == ST_ENTRY)
        else $error("wake not four extra cycles");
    AST_HOLD_AFTER_SEI: assert property (@(posedge clock) disable iff (!rst_n) // [R16]
        global_enable_op |=> q.hold_one)
        else $error("no instruction held after enable");
endmodule : cis_sequencer

`default_nettype wire

// *** cis_pipe_model.sv ***
// Purpose: pipeline stand-in facing the interrupt sequencer
// Assumes: one instruction ends per cycle while run is high and irq_stall is low
// Notes: cur_pc follows pc_load, otherwise counts up per instruction
`timescale 1ns/1ps
`default_nettype none
module cis_pipe_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic run,
    input wire logic irq_stall,
    input wire logic pc_load,
    input wire logic [15:0] pc_target,
    output logic instr_done,
    output logic [15:0] cur_pc
);
    // no boundaries while the sequencer owns the pc
    assign instr_done = run & ~irq_stall;
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            cur_pc <= 16'h0000;
        else if (pc_load)
            cur_pc <= pc_target;
        else if (instr_done)
            cur_pc <= cur_pc + 16'h0001;
    end
endmodule : cis_pipe_model
`default_nettype wire

// *** test_cis_sequencer.sv ***
// Purpose: self-checking bench for the interrupt sequencer
// Assumes: zero-wait AHB-Lite slave, sources pass a 3-flop sync
// Notes: boot-section lock stays low; app lock, fuse and sleep are each driven high in a test; vectors checked by value
`timescale 1ns/1ps
`default_nettype none
module test_cis_sequencer;
    import cis_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] src_event = 8'h00;
    logic [7:0] src_is_level = 8'h00;
    logic dis_op = 1'b0;
    logic en_op = 1'b0;
    logic ret_op = 1'b0;
    logic run = 1'b0;
    logic multi = 1'b0;
    logic sleep_in = 1'b0;
    logic lock_app = 1'b0;
    logic fuse = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd_smp, rd;
    logic hreadyout, hresp, irq_stall, pc_load, push_pulse, pop_pulse, instr_done;
    logic [15:0] pc_target, ret_addr, sp_out, cur_pc, last_tgt;
    int n_errors = 0;
    int n_compared = 0;
    int n_load = 0;
    int n_pop = 0;
    int stall_len = 0;
    int cyc = 0;
    int s0;
    always #2.5 clock = ~clock;
    cis_sequencer dut (.clock(clock), .rst_n(rst_n), .src_event(src_event),
        .src_is_level(src_is_level), .instr_done(instr_done), .instr_multi_busy(multi),
        .global_disable_op(dis_op), .global_enable_op(en_op),
        .return_from_handler(ret_op), .sleeping(sleep_in), .boot_reset_vector_fuse(fuse),
        .boot_lock_app_bits(lock_app), .boot_lock_boot_bits(1'b0), .cur_pc(cur_pc),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .irq_stall(irq_stall), .pc_load(pc_load), .pc_target(pc_target),
        .push_pulse(push_pulse), .pop_pulse(pop_pulse), .ret_addr(ret_addr),
        .sp_out(sp_out));
    cis_pipe_model pipe (.clock(clock), .rst_n(rst_n), .run(run), .irq_stall(irq_stall),
        .pc_load(pc_load), .pc_target(pc_target), .instr_done(instr_done),
        .cur_pc(cur_pc));
    // ----------------------------------------
    // monitors and hang guard
    // ----------------------------------------
    always @(posedge clock)
    begin
        rd_smp <= hrdata;
        cyc <= cyc + 1;
        if (irq_stall)
            stall_len <= stall_len + 1;
        if (pop_pulse)
            n_pop <= n_pop + 1;
        if (pc_load)
        begin
            n_load <= n_load + 1;
            last_tgt <= pc_target;
        end
        if (cyc == 20000)
        begin
            n_errors++;
            give_verdict();
        end
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // address phase held until hready, data phase likewise; read data at 2nd edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        haddr <= {24'h000000, a};
        hwrite <= wr;
        htrans <= 2'h2;
        hsel <= 1'b1;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge clock); while (hreadyout !== 1'b1);
        #1 rd = rd_smp;
    endtask : bus
    task automatic cycles(input int n);
        repeat (n) @(posedge clock);
    endtask : cycles
    task automatic wait_load(input int n);
        int k;
        k = 0;
        while (n_load < n && k < 100)
        begin
            @(posedge clock);
            k++;
        end
        #1 check(32'(n_load), 32'(n));
    endtask : wait_load
    task automatic pulse_src(input logic [7:0] m);
        src_event <= m;
        cycles(8);
        src_event <= 8'h00;
        cycles(8);
    endtask : pulse_src
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        cycles(10);
        rst_n <= 1'b1;
        wait_load(1);
        check(last_tgt, 32'h0);
        bus(0, OFS_FLAGS, 0);
        check(rd, 32'h0);
        bus(0, OFS_SP, 0);
        check(rd, 32'(SP_RESET));
        bus(0, OFS_BOOT, 0);
        check(rd, 32'(BOOT_START_RESET));
        bus(0, 8'h1C, 0);
        check(rd, 32'h0);
        $display("test reset done");
        pulse_src(8'h02);
        bus(0, OFS_PENDING, 0);
        check(rd, 32'h02);
        bus(1, OFS_PENDING, 32'h0);
        bus(0, OFS_PENDING, 0);
        check(rd, 32'h02);
        bus(1, OFS_PENDING, 32'h02);
        bus(0, OFS_PENDING, 0);
        check(rd, 32'h0);
        $display("test flags done");
        bus(1, OFS_ENABLE, 32'h05);
        pulse_src(8'h05);
        run <= 1'b1;
        cycles(10);
        check(32'(n_load), 32'h1);
        bus(0, OFS_PENDING, 0);
        check(rd, 32'h05);
        s0 = stall_len;
        en_op <= 1'b1;
        @(posedge clock);
        en_op <= 1'b0;
        wait_load(2);
        check(last_tgt, 32'(VEC_STRIDE));
        cycles(JUMP_CYC + 2);
        check(32'(stall_len - s0), 32'(ENTRY_CYC + JUMP_CYC));
        bus(0, OFS_FLAGS, 0);
        check(32'(rd[GATE_BIT]), 32'h0);
        bus(0, OFS_PENDING, 0);
        check(rd, 32'h04);
        bus(0, OFS_SP, 0);
        check(rd, 32'(SP_RESET - 16'h0002));
        run <= 1'b0;
        ret_op <= 1'b1;
        @(posedge clock);
        ret_op <= 1'b0;
        cycles(RETURN_CYC + 2);
        check(32'(n_pop), 32'h1);
        bus(0, OFS_SP, 0);
        check(rd, 32'(SP_RESET));
        bus(0, OFS_FLAGS, 0);
        check(32'(rd[GATE_BIT]), 32'h1);
        run <= 1'b1;
        wait_load(3);
        check(last_tgt, 32'(VEC_STRIDE * 3));
        $display("test entry and return done");
        bus(1, OFS_CTRL, 32'h02);
        bus(1, OFS_ENABLE, 32'h02);
        pulse_src(8'h02);
        bus(1, OFS_FLAGS, 32'h80);
        wait_load(4);
        check(last_tgt, 32'(BOOT_START_RESET + VEC_STRIDE * 2));
        $display("test relocation done");
        bus(1, OFS_CTRL, 32'h0);
        bus(1, OFS_ENABLE, 32'h08);
        src_is_level <= 8'h08;
        pulse_src(8'h08);
        bus(1, OFS_FLAGS, 32'h80);
        cycles(20);
        check(32'(n_load), 32'h4);
        run <= 1'b0;
        src_event <= 8'h08;
        cycles(8);
        run <= 1'b1;
        dis_op <= 1'b1;
        @(posedge clock);
        dis_op <= 1'b0;
        cycles(20);
        check(32'(n_load), 32'h4);
        bus(1, OFS_FLAGS, 32'h80);
        wait_load(5);
        check(last_tgt, 32'(VEC_STRIDE * 4));
        src_event <= 8'h00;
        $display("test level and disable done");
        multi <= 1'b1;
        bus(1, OFS_ENABLE, 32'h01);
        pulse_src(8'h01);
        bus(1, OFS_FLAGS, 32'h80);
        cycles(10);
        check(32'(n_load), 32'h5);
        multi <= 1'b0;
        wait_load(6);
        check(last_tgt, 32'(VEC_STRIDE));
        lock_app <= 1'b1;
        pulse_src(8'h01);
        bus(1, OFS_FLAGS, 32'h80);
        cycles(10);
        check(32'(n_load), 32'h6);
        s0 = stall_len;
        lock_app <= 1'b0;
        sleep_in <= 1'b1;
        wait_load(7);
        cycles(JUMP_CYC + 2);
        check(32'(stall_len - s0),
            32'(WAKE_EXTRA_CYC) + 32'(ENTRY_CYC) + 32'(JUMP_CYC));
        sleep_in <= 1'b0;
        $display("test busy, lock and wake done");
        fuse <= 1'b1;
        rst_n <= 1'b0;
        cycles(2);
        rst_n <= 1'b1;
        wait_load(8);
        check(last_tgt, 32'(BOOT_BASE_RST));
        $display("test boot reset vector done");
        give_verdict();
    end
endmodule : test_cis_sequencer
`default_nettype wire
